// ===== fbs_pkg.sv
// Shared constants and types of the fieldbus slave glue logic.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package fbs_pkg;

    // ------------------------------------------------------------
    // Station address switches
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned SW_W = 8;
    localparam int unsigned SW_RESERVED_BIT = 7;
    localparam logic [6:0] ADDR_RESET = 7'h00;

    // ------------------------------------------------------------
    // Set-parameters telegram layout (byte positions count from 1)
    // ------------------------------------------------------------
    localparam int unsigned PRM_STD_LEN = 7;
    localparam logic [7:0] PRM_EXT_FIRST = 8'h08;
    localparam logic [7:0] PRM_EXT_LAST = 8'h0A;
    localparam int unsigned PRM_MFR_LEN = 8;
    localparam logic [7:0] PRM_MIN_LEN = 8'h07;
    localparam logic [7:0] PRM_MAX_LEN = 8'hF4;
    localparam logic [7:0] PRM_CNT_MAX = 8'hFF;

    // ------------------------------------------------------------
    // Relays, sensor setup and bit-rate detection
    // ------------------------------------------------------------
    localparam logic RELAY_RESET = 1'b0;
    localparam int unsigned SETUP_W = 8;
    localparam int unsigned SETUP_TEST_BIT = 0;
    localparam int unsigned RUN_W = 16;
    localparam logic [15:0] RUN_MAX = 16'hFFFF;
    localparam int unsigned CLK_HZ = 10000000;

    typedef enum logic [1:0] {
        FBS_WAIT_PRM = 2'b01,
        FBS_DATA_EX = 2'b10
    } fbs_link_state_type;

endpackage

// ===== fbs_prm_if.sv
// Carrier between the top module and the parameter telegram checker.
// Assumes both ends run on the same clock.
interface fbs_prm_if #(
    parameter int unsigned MFR_BYTES = 8
);
    logic byte_valid;
    logic [7:0] byte_data;
    logic frame_start;
    logic frame_end;
    logic done;
    logic ok;
    logic [8*7-1:0] std_fields;
    logic [8*MFR_BYTES-1:0] mfr_fields;

    modport check (
        input byte_valid, byte_data, frame_start, frame_end,
        output done, ok, std_fields, mfr_fields
    );
    modport host (
        output byte_valid, byte_data, frame_start, frame_end,
        input done, ok, std_fields, mfr_fields
    );
endinterface

// ===== fbs_prm_check.sv
// Length check and field capture of one set-parameters telegram.
// Assumes frame_start precedes the bytes and frame_end follows the last.
module fbs_prm_check
    import fbs_pkg::*;
#(
    parameter int unsigned MFR_BYTES = PRM_MFR_LEN
)
(
    input wire logic clk,       // System clock.
    input wire logic reset,     // Synchronous reset, active high.
    fbs_prm_if.check prm        // Telegram byte stream and result.
);
    localparam logic [7:0] FULL_LEN = 8'(PRM_EXT_LAST) + 8'(MFR_BYTES);

    logic [7:0] cnt_q, cnt_d;
    logic done_q, done_d;
    logic ok_q, ok_d;
    logic [8*7-1:0] std_q, std_d;
    logic [8*MFR_BYTES-1:0] mfr_q, mfr_d;

    always_comb
    begin
        cnt_d = cnt_q;
        std_d = std_q;
        mfr_d = mfr_q;
        done_d = 1'b0;
        ok_d = ok_q;
        if (prm.frame_start)
        begin
            cnt_d = 8'h00;
        end
        else if (prm.frame_end)
        begin
            done_d = 1'b1;
            // Fewer than the full module block leaves the device unset.
            ok_d = (cnt_q >= PRM_MIN_LEN) && (cnt_q <= PRM_MAX_LEN) &&
                   (cnt_q >= FULL_LEN);
        end
        else if (prm.byte_valid)
        begin
            if (cnt_q != PRM_CNT_MAX)
            begin
                cnt_d = cnt_q + 8'h01;
            end
            for (int i = 0; i < PRM_STD_LEN; i++)
            begin
                if (cnt_q == 8'(i))
                begin
                    std_d[8*i +: 8] = prm.byte_data;
                end
            end
            // Positions 8 to 10 match neither loop and are dropped.
            for (int j = 0; j < MFR_BYTES; j++)
            begin
                if (cnt_q == PRM_EXT_LAST + 8'(j))
                begin
                    mfr_d[8*j +: 8] = prm.byte_data;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt_q <= 8'h00;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            std_q <= '0;
            mfr_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
            done_q <= done_d;
            ok_q <= ok_d;
            std_q <= std_d;
            mfr_q <= mfr_d;
        end
    end

    assign prm.done = done_q;
    assign prm.ok = ok_q;
    assign prm.std_fields = std_q;
    assign prm.mfr_fields = mfr_q;

endmodule // fbs_prm_check

// ===== fbs_top.sv
// Glue logic of the fieldbus slave option module of a door controller.
// Assumes a telegram receiver that delivers parameter bytes and data
// exchange requests already decoded, all synchronous to clk.

// Functional notes
// - Station address comes from switches 1 to 7, on reads as 1.
// - Switch 8 is reserved and never enters the address.
// - Every address from 0 to 127 is accepted.
// - Address is taken only at reset or restart, never during operation.
// - Without test, closed relay shuts only for closed reached by drive order.
// - Pushing the door shut never makes the closed state.
// - Leaving the position by drive or pushing ends the state and relay.
// - During sensor test with setup bit 0 set, the closed relay follows the sensor check output.
// - Sensor setup parameter decides whether the test may take the relay.
// - Open relay shuts while the open state holds, from door position.
// - Open state is reached by drive order or by pushing.
// - Cyclic data is refused until a parameter telegram is accepted.
// - A valid parameter telegram is answered with a short acknowledge, unless another master holds the link.
// - Parameter telegram holds 7 to 244 bytes; first 7 are standard; only 18 to 244 are accepted here.
// - Bytes 8 to 10 are ignored; later bytes are module specific.
// - The module specific part holds 8 bytes, passed out undecoded on mfr_params.
// - Data is exchanged with one master only, basic cyclic protocol.
// - Bus bit rate is detected automatically from the line.
module fbs_top
    import fbs_pkg::*;
#(
    parameter int unsigned MFR_BYTES = PRM_MFR_LEN
)
(
    input wire logic clk,                          // System clock.
    input wire logic reset,                        // Sync reset, high.
    input wire logic restart,                      // System restart pulse.
    input wire logic [SW_W-1:0] station_address_switch_bank, // Switches.
    input wire logic door_at_closed,               // Door in closed spot.
    input wire logic door_at_open,                 // Door in open spot.
    input wire logic drive_order_active,           // Motion by drive order.
    input wire logic sensor_test_active,           // Sensor test running.
    input wire logic sensor_check_output,          // Sensor test signal.
    input wire logic [SETUP_W-1:0] sensor_setup_parameter, // Setup.
    input wire logic bus_rxd,                      // Bus receive line.
    input wire logic prm_start,                    // Parameter frame begins.
    input wire logic prm_byte_valid,               // Parameter byte strobe.
    input wire logic [7:0] prm_byte,               // Parameter byte.
    input wire logic prm_end,                      // Parameter frame ends.
    input wire logic [ADDR_W-1:0] prm_master_addr, // Sender, with prm_end.
    input wire logic dx_request,                   // Data exchange request.
    input wire logic [ADDR_W-1:0] dx_master_addr,  // Sender of dx_request.
    output logic [ADDR_W-1:0] station_address,     // Active address.
    output logic relay_closed,                     // Closed relay contact.
    output logic relay_open,                       // Open relay contact.
    output logic prm_ack,                          // Short acknowledge.
    output logic prm_reject,                       // Telegram not accepted.
    output logic dx_grant,                         // Exchange answered.
    output logic dx_refuse,                        // Exchange refused.
    output logic params_valid,                     // Parameters accepted.
    output logic [8*PRM_STD_LEN-1:0] std_params,   // Standard fields.
    output logic [8*MFR_BYTES-1:0] mfr_params,     // Module fields.
    output logic [RUN_W-1:0] bit_period,           // Clocks per bit.
    output logic bit_period_valid                  // bit_period is known.
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (MFR_BYTES < 1 || PRM_EXT_LAST + MFR_BYTES > PRM_MAX_LEN)
    begin : g_bad_mfr
        $error("MFR_BYTES does not fit a parameter telegram");
    end

    // ------------------------------------------------------------
    // Station address
    // ------------------------------------------------------------
    logic load_q, load_d;
    logic [ADDR_W-1:0] addr_q, addr_d;

    always_comb
    begin
        load_d = restart;
        addr_d = addr_q;
        // A pending load is taken the cycle after reset or restart.
        if (load_q)
        begin
            // Bit n-1 of the bank is switch n, so switch 1 is the LSB.
            addr_d = station_address_switch_bank[ADDR_W-1:0];
            // Bit SW_RESERVED_BIT is never looked at.
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            load_q <= 1'b1;
            addr_q <= ADDR_RESET;
        end
        else
        begin
            load_q <= load_d;
            addr_q <= addr_d;
        end
    end

    assign station_address = addr_q;

    // ------------------------------------------------------------
    // Door states and relays
    // ------------------------------------------------------------
    logic closed_st_q, closed_st_d;
    logic open_st_q, open_st_d;
    logic rel_c_q, rel_c_d;
    logic rel_o_q, rel_o_d;
    logic test_sel;

    always_comb
    begin
        // Held only while the door stays in place; leaving ends it.
        if (closed_st_q)
        begin
            closed_st_d = door_at_closed;
        end
        else
        begin
            closed_st_d = door_at_closed && drive_order_active;
        end
        open_st_d = door_at_open;
        test_sel = sensor_test_active &&
                   sensor_setup_parameter[SETUP_TEST_BIT];
        if (test_sel)
        begin
            rel_c_d = sensor_check_output;
        end
        else
        begin
            rel_c_d = closed_st_q;
        end
        rel_o_d = open_st_q;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            closed_st_q <= 1'b0;
            open_st_q <= 1'b0;
            rel_c_q <= RELAY_RESET;
            rel_o_q <= RELAY_RESET;
        end
        else
        begin
            closed_st_q <= closed_st_d;
            open_st_q <= open_st_d;
            rel_c_q <= rel_c_d;
            rel_o_q <= rel_o_d;
        end
    end

    assign relay_closed = rel_c_q;
    assign relay_open = rel_o_q;

    // ------------------------------------------------------------
    // Parameter telegram check
    // ------------------------------------------------------------
    fbs_prm_if #(.MFR_BYTES(MFR_BYTES)) prm_bus ();

    assign prm_bus.byte_valid = prm_byte_valid;
    assign prm_bus.byte_data = prm_byte;
    assign prm_bus.frame_start = prm_start;
    assign prm_bus.frame_end = prm_end;

    fbs_prm_check #(.MFR_BYTES(MFR_BYTES)) u_check (
        .clk(clk),
        .reset(reset),
        .prm(prm_bus.check)
    );

    // ------------------------------------------------------------
    // Link state: parameter phase and cyclic data exchange
    // ------------------------------------------------------------
    fbs_link_state_type state_q, state_d;
    logic [ADDR_W-1:0] pend_q, pend_d;
    logic [ADDR_W-1:0] owner_q, owner_d;
    logic ack_q, ack_d;
    logic rej_q, rej_d;
    logic grant_q, grant_d;
    logic refuse_q, refuse_d;
    logic [8*PRM_STD_LEN-1:0] std_q, std_d;
    logic [8*MFR_BYTES-1:0] mfr_q, mfr_d;
    logic from_owner;

    always_comb
    begin
        state_d = state_q;
        pend_d = prm_end ? prm_master_addr : pend_q;
        owner_d = owner_q;
        ack_d = 1'b0;
        rej_d = 1'b0;
        grant_d = 1'b0;
        refuse_d = 1'b0;
        std_d = std_q;
        mfr_d = mfr_q;
        from_owner = (pend_q == owner_q);
        unique case (state_q)
            FBS_WAIT_PRM:
            begin
                if (prm_bus.done && prm_bus.ok)
                begin
                    ack_d = 1'b1;
                    owner_d = pend_q;
                    std_d = prm_bus.std_fields;
                    mfr_d = prm_bus.mfr_fields;
                    state_d = FBS_DATA_EX;
                end
                else if (prm_bus.done)
                begin
                    rej_d = 1'b1;
                end
                refuse_d = dx_request;
            end
            FBS_DATA_EX:
            begin
                // Another master is turned away while one holds the link.
                if (prm_bus.done && prm_bus.ok && from_owner)
                begin
                    ack_d = 1'b1;
                    std_d = prm_bus.std_fields;
                    mfr_d = prm_bus.mfr_fields;
                end
                else if (prm_bus.done && from_owner)
                begin
                    rej_d = 1'b1;
                    state_d = FBS_WAIT_PRM;
                end
                else if (prm_bus.done)
                begin
                    rej_d = 1'b1;
                end
                grant_d = dx_request && (dx_master_addr == owner_q);
                refuse_d = dx_request && (dx_master_addr != owner_q);
            end
        endcase
        if (restart)
        begin
            state_d = FBS_WAIT_PRM;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= FBS_WAIT_PRM;
            pend_q <= '0;
            owner_q <= '0;
            ack_q <= 1'b0;
            rej_q <= 1'b0;
            grant_q <= 1'b0;
            refuse_q <= 1'b0;
            std_q <= '0;
            mfr_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            pend_q <= pend_d;
            owner_q <= owner_d;
            ack_q <= ack_d;
            rej_q <= rej_d;
            grant_q <= grant_d;
            refuse_q <= refuse_d;
            std_q <= std_d;
            mfr_q <= mfr_d;
        end
    end

    assign prm_ack = ack_q;
    assign prm_reject = rej_q;
    assign dx_grant = grant_q;
    assign dx_refuse = refuse_q;
    assign params_valid = state_q[1];
    assign std_params = std_q;
    assign mfr_params = mfr_q;

    // ------------------------------------------------------------
    // Bit-rate detection
    // ------------------------------------------------------------
    // The shortest run between line edges is one bit time. At a 10 MHz
    // clock only rates well below the clock are resolved; faster rates
    // give a period of one or two clocks and must be refined elsewhere.
    logic rxd_prev_q, rxd_prev_d;
    logic [RUN_W-1:0] run_q, run_d;
    logic [RUN_W-1:0] min_q, min_d;
    logic minv_q, minv_d;

    always_comb
    begin
        rxd_prev_d = bus_rxd;
        run_d = (run_q == RUN_MAX) ? run_q : run_q + 16'h0001;
        min_d = min_q;
        minv_d = minv_q;
        if (bus_rxd != rxd_prev_q)
        begin
            run_d = 16'h0001;
            if (!minv_q || run_q < min_q)
            begin
                min_d = run_q;
                minv_d = (run_q != RUN_MAX);
            end
        end
        if (restart)
        begin
            minv_d = 1'b0;
            min_d = RUN_MAX;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rxd_prev_q <= 1'b1;
            run_q <= 16'h0001;
            min_q <= RUN_MAX;
            minv_q <= 1'b0;
        end
        else
        begin
            rxd_prev_q <= rxd_prev_d;
            run_q <= run_d;
            min_q <= min_d;
            minv_q <= minv_d;
        end
    end

    assign bit_period = min_q;
    assign bit_period_valid = minv_q;

endmodule // fbs_top

// ===== fbs_properties.sv
// Port-level checker of the fieldbus slave glue logic.
// Assumes it is bound to fbs_top and shares its clock and reset.
module fbs_properties
    import fbs_pkg::*;
#(
    parameter int unsigned MFR_BYTES = PRM_MFR_LEN
)
(
    input wire logic clk, // Clock.
    input wire logic reset, // Reset.
    input wire logic restart, // Restart.
    input wire logic [SW_W-1:0] station_address_switch_bank, // Bank.
    input wire logic door_at_closed, // Closed spot.
    input wire logic door_at_open, // Open spot.
    input wire logic drive_order_active, // Drive.
    input wire logic sensor_test_active, // Test.
    input wire logic sensor_check_output, // Test signal.
    input wire logic [SETUP_W-1:0] sensor_setup_parameter, // Setup.
    input wire logic prm_end, // Frame end.
    input wire logic dx_request, // Request.
    input wire logic [ADDR_W-1:0] station_address, // Address.
    input wire logic relay_closed, // Closed relay.
    input wire logic relay_open, // Open relay.
    input wire logic prm_ack, // Accept.
    input wire logic prm_reject, // Refuse.
    input wire logic dx_grant, // Grant.
    input wire logic dx_refuse, // Refuse.
    input wire logic params_valid, // Accepted.
    input wire logic [RUN_W-1:0] bit_period, // Period.
    input wire logic bit_period_valid // Period known.
);
    timeunit 1ns / 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Address, relays and telegram answers
    // ------------------------------------------------------------
    addr_on_restart_a: assert property (restart |=> ##1
        station_address == $past(station_address_switch_bank[ADDR_W-1:0]))
        else $error("address not loaded after restart");
    addr_held_a: assert property ($changed(station_address) |->
        $past(restart, 2) || $past(reset, 2))
        else $error("address changed without restart");
    closed_by_drive_a: assert property ($rose(relay_closed) &&
        !$past(sensor_test_active) && !$past(sensor_test_active, 2) |->
        $past(door_at_closed, 2) && $past(drive_order_active, 2))
        else $error("closed relay shut without drive order");
    closed_leave_a: assert property (!door_at_closed ##1
        !sensor_test_active |=> !relay_closed)
        else $error("closed relay held after door left");
    test_follow_a: assert property (sensor_test_active &&
        sensor_setup_parameter[SETUP_TEST_BIT] |=>
        relay_closed == $past(sensor_check_output))
        else $error("closed relay ignores sensor test signal");
    open_state_a: assert property (!$past(reset) && !$past(reset, 2) |->
        relay_open == $past(door_at_open, 2))
        else $error("open relay does not follow open state");
    prm_answer_a: assert property (prm_end |-> ##2
        (prm_ack ^ prm_reject))
        else $error("parameter telegram not answered once");
    prm_cause_a: assert property (prm_ack || prm_reject |->
        $past(prm_end, 2))
        else $error("parameter answer without telegram");
    valid_on_ack_a: assert property ($rose(params_valid) |-> prm_ack)
        else $error("parameters valid without acknowledge");
    dx_answer_a: assert property (dx_request |=>
        (dx_grant ^ dx_refuse))
        else $error("exchange request not answered once");
    dx_gate_a: assert property (dx_grant |-> $past(params_valid))
        else $error("exchange granted before parameters");
    rate_known_a: assert property (bit_period_valid |->
        bit_period != RUN_MAX)
        else $error("bit period valid but unknown");

    cover property (prm_ack);
    cover property (dx_grant);
    cover property (sensor_test_active && relay_closed);
endmodule // fbs_properties

// ===== fbs_master_model.sv
// Behavioural class 1 master that parameterises and polls the slave.
// Assumes one bench process calls its tasks at a time.
module fbs_master_model
    import fbs_pkg::*;
(
    input wire logic clk, // Clock.
    output logic bus_rxd, // Bus line, idle high.
    output logic prm_start, // Frame begins.
    output logic prm_byte_valid, // Byte strobe.
    output logic [7:0] prm_byte, // Byte.
    output logic prm_end, // Frame ends.
    output logic [ADDR_W-1:0] prm_master_addr, // Sender.
    output logic dx_request, // Request.
    output logic [ADDR_W-1:0] dx_master_addr // Sender.
);
    timeunit 1ns / 1ns;
    initial
    begin
        {prm_start, prm_byte_valid, prm_end, dx_request} = 4'h0;
        {prm_byte, prm_master_addr, dx_master_addr} = 22'h0;
        bus_rxd = 1'b1;
    end

    // Outside a strobe the data shows the inverse, never a stale match.
    task automatic send_prm(input logic [6:0] addr, input logic [7:0] d[$]);
        @(negedge clk);
        prm_start = 1'b1;
        foreach (d[i])
        begin
            @(negedge clk);
            prm_start = 1'b0;
            prm_byte_valid = 1'b1;
            prm_byte = d[i];
            bus_rxd = ~bus_rxd;
        end
        @(negedge clk);
        prm_byte_valid = 1'b0;
        prm_byte = ~prm_byte;
        prm_end = 1'b1;
        prm_master_addr = addr;
        @(negedge clk);
        prm_end = 1'b0;
        prm_master_addr = ~addr;
        bus_rxd = 1'b1;
    endtask

    task automatic send_dx(input logic [6:0] addr);
        @(negedge clk);
        dx_request = 1'b1;
        dx_master_addr = addr;
        @(negedge clk);
        dx_request = 1'b0;
        dx_master_addr = ~addr;
    endtask
endmodule // fbs_master_model

// ===== test_fbs_top.sv
// Self-checking bench of the fieldbus slave glue with a master model.
// Assumes the package, carrier, design and model files compile first.
module test_fbs_top
    import fbs_pkg::*;
;
    timeunit 1ns / 1ns;
    localparam int unsigned MFR = PRM_MFR_LEN;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic restart = 1'b0;
    logic [7:0] bank, prm_byte;
    logic door_c = 1'b0, door_o = 1'b0, drive = 1'b0;
    logic test = 1'b0, chk_out = 1'b0;
    logic [7:0] setup = 8'h00;
    logic bus_rxd, prm_start, prm_bv, prm_end, dx_req;
    logic [6:0] prm_addr, dx_addr, sa, exp_addr;
    logic rc, ro, ack, rej, grant, refuse, pv, bpv;
    logic [55:0] std;
    logic [15:0] bp;
    logic [8*MFR-1:0] mfr;
    logic [31:0] seed = 32'h4B08182A;
    logic [7:0] q[$];
    int n_fail = 0, compares = 0, owner = -1;
    bit pvm = 1'b0;

    always #50 clk = ~clk;

    fbs_top #(.MFR_BYTES(MFR)) DUT (.clk(clk), .reset(reset),
        .restart(restart), .station_address_switch_bank(bank),
        .door_at_closed(door_c), .door_at_open(door_o),
        .drive_order_active(drive), .sensor_test_active(test),
        .sensor_check_output(chk_out), .sensor_setup_parameter(setup),
        .bus_rxd(bus_rxd), .prm_start(prm_start), .prm_byte_valid(prm_bv),
        .prm_byte(prm_byte), .prm_end(prm_end), .prm_master_addr(prm_addr),
        .dx_request(dx_req), .dx_master_addr(dx_addr),
        .station_address(sa), .relay_closed(rc), .relay_open(ro),
        .prm_ack(ack), .prm_reject(rej), .dx_grant(grant),
        .dx_refuse(refuse), .params_valid(pv), .std_params(std),
        .mfr_params(mfr), .bit_period(bp), .bit_period_valid(bpv));

    fbs_master_model u_master (.clk(clk), .bus_rxd(bus_rxd),
        .prm_start(prm_start), .prm_byte_valid(prm_bv),
        .prm_byte(prm_byte), .prm_end(prm_end), .prm_master_addr(prm_addr),
        .dx_request(dx_req), .dx_master_addr(dx_addr));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string what, input logic [63:0] exp,
        input logic [63:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Answers are one-cycle pulses, so they are looked at every cycle.
    task automatic answer(output logic [3:0] got);
        got = {ack, rej, grant, refuse};
        for (int i = 0; i < 8 && got === 4'h0; i++)
        begin
            @(negedge clk);
            got = {ack, rej, grant, refuse};
        end
        if (got === 4'h0)
        begin
            n_fail++;
            end_sim();
        end
    endtask

    task automatic new_bank(input logic [7:0] b, input bit rs);
        @(negedge clk);
        bank = b;
        restart = rs;
        @(negedge clk);
        restart = 1'b0;
        repeat (3) @(negedge clk);
        if (rs)
            exp_addr = b[6:0];
        chk("station_address", exp_addr, sa);
    endtask

    task automatic relay(input logic [4:0] in, input logic ec, eo);
        @(negedge clk);
        {door_c, drive, test, chk_out, door_o} = in;
        repeat (3) @(negedge clk);
        chk("relay_closed", ec, rc);
        chk("relay_open", eo, ro);
    endtask

    task automatic prm(input int len, input logic [6:0] addr);
        logic [3:0] got;
        logic [63:0] e_std, e_mfr;
        bit ok;
        q.delete();
        repeat (len) q.push_back(8'(rnd()));
        ok = len >= 18 && len <= 244;
        u_master.send_prm(addr, q);
        answer(got);
        chk("prm answer", ok ? 4'h8 : 4'h4, got);
        chk("bit_period", 17'h10001, {bpv, bp});
        pvm = ok;
        if (ok)
        begin
            owner = addr;
            e_std = '0;
            for (int k = 0; k < 8; k++)
                e_mfr[8*k +: 8] = q[10+k];
            for (int k = 0; k < 7; k++)
                e_std[8*k +: 8] = q[k];
            chk("std_params", e_std, std);
            chk("mfr_params", e_mfr, mfr);
            chk("params_valid", 1'b1, pv);
        end
    endtask

    task automatic dx(input logic [6:0] addr);
        logic [3:0] got;
        u_master.send_dx(addr);
        answer(got);
        chk("dx answer", (pvm && addr == owner) ? 4'h2 : 4'h1, got);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        bank = 8'(rnd());
        exp_addr = bank[6:0];
        repeat (20) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        chk("station_address", exp_addr, sa);
        new_bank(8'h80, 1'b1);
        new_bank(8'hFF, 1'b1);
        new_bank(8'h59, 1'b1);
        for (int i = 0; i < 4; i++)
            new_bank(8'(rnd()), i[0]);
        relay(5'b10000, 1'b0, 1'b0);
        relay(5'b11000, 1'b1, 1'b0);
        relay(5'b10000, 1'b1, 1'b0);
        relay(5'b00000, 1'b0, 1'b0);
        relay(5'b00001, 1'b0, 1'b1);
        relay(5'b01000, 1'b0, 1'b0);
        setup = 8'h01;
        relay(5'b00110, 1'b1, 1'b0);
        relay(5'b11100, 1'b0, 1'b0);
        setup = 8'h00;
        relay(5'b11110, 1'b1, 1'b0);
        relay(5'b00110, 1'b0, 1'b0);
        dx(7'h05);
        prm(17, 7'h05);
        prm(18, 7'h05);
        dx(7'h05);
        dx(7'h06);
        prm(245, 7'h05);
        dx(7'h05);
        prm(244, 7'h05);
        dx(7'h05);
        end_sim();
    end
endmodule // test_fbs_top

bind fbs_top fbs_properties #(.MFR_BYTES(MFR_BYTES)) u_props (.clk(clk),
    .reset(reset), .restart(restart),
    .station_address_switch_bank(station_address_switch_bank),
    .door_at_closed(door_at_closed), .door_at_open(door_at_open),
    .drive_order_active(drive_order_active),
    .sensor_test_active(sensor_test_active),
    .sensor_check_output(sensor_check_output),
    .sensor_setup_parameter(sensor_setup_parameter), .prm_end(prm_end),
    .dx_request(dx_request), .station_address(station_address),
    .relay_closed(relay_closed), .relay_open(relay_open),
    .prm_ack(prm_ack), .prm_reject(prm_reject), .dx_grant(dx_grant),
    .dx_refuse(dx_refuse), .params_valid(params_valid),
    .bit_period(bit_period), .bit_period_valid(bit_period_valid));
